// >>> pkg/xid_cfg.svh
// constants for the exclusive-or execute datapath
`ifndef XID_CFG_SVH
`define XID_CFG_SVH
`define XID_DATA_W 8
`define XID_OP_W 12
`define XID_ADDR_W 5
`define XID_FR_DEPTH 32
`define XID_OPC_TO_FR 7'h0D
`define XID_OPC_TO_ACC 7'h0C
`define XID_OPC_LIT 4'hF
`define XID_ACC_RST 8'h00
`define XID_FR_RST 8'h00
`define XID_ZERO 8'h00
`endif

// >>> pkg/xid_pkg.sv
// types for the exclusive-or execute datapath
`include "xid_cfg.svh"
package xid_pkg;
  typedef logic [`XID_DATA_W-1:0] xid_byte_t;
  typedef logic [`XID_ADDR_W-1:0] xid_addr_t;
  typedef logic [`XID_OP_W-1:0] xid_op_t;
  // decoded form of one instruction word
  typedef enum logic [1:0] {XID_NONE, XID_TO_FR, XID_TO_ACC, XID_LIT} xid_form_t;
  // write port toward the file registers
  typedef struct packed {
    logic we;
    xid_addr_t addr;
    xid_byte_t data;
  } xid_fr_wr_t;
endpackage

// >>> design/xid_decode.sv
// opcode decoder for the three exclusive-or forms
`timescale 1ns/100ps
`include "xid_cfg.svh"
module xid_decode
(
  // instruction word
  input wire xid_pkg::xid_op_t i_op,
  // decoded outputs
  output xid_pkg::xid_form_t o_form,
  output xid_pkg::xid_addr_t o_addr,
  output xid_pkg::xid_byte_t o_lit
);
  import xid_pkg::*;

  // pattern matches on the upper opcode bits
  wire hit_to_fr = (i_op[11:5] == `XID_OPC_TO_FR);
  wire hit_to_acc = (i_op[11:5] == `XID_OPC_TO_ACC);
  wire hit_lit = (i_op[11:8] == `XID_OPC_LIT);

  // the patterns are disjoint, so the order here is arbitrary
  assign o_form = hit_to_fr ? XID_TO_FR : (hit_to_acc ? XID_TO_ACC : (hit_lit ? XID_LIT : XID_NONE));
  assign o_addr = i_op[4:0];
  assign o_lit = i_op[7:0];
endmodule

// >>> design/xid_datapath.sv
// execute stage for the exclusive-or instructions
// Overview of operation
// - 0001101 form: register xor acc into register
// - register-destination form keeps accumulator unchanged
// - 0001100 form: xor into acc, register kept
// - 1111 form: acc xor literal into acc
// - zero result sets zero flag, for all three forms
// - nonzero result clears the zero flag
`timescale 1ns/100ps
`include "xid_cfg.svh"
module xid_datapath
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // instruction issue, one word per enabled cycle
  input wire logic i_valid,
  input wire xid_pkg::xid_op_t i_op,
  // file register write back
  output xid_pkg::xid_fr_wr_t o_fr_wr,
  // architectural state
  output xid_pkg::xid_byte_t o_acc,
  output logic o_zero,
  output logic o_done
);
  import xid_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state
  xid_byte_t fr_mem [`XID_FR_DEPTH]; // the file registers
  xid_byte_t acc_q, acc_d; // accumulator
  logic zero_q, zero_d; // zero flag
  xid_fr_wr_t wr_q, wr_d; // registered write strobe
  logic done_q; // retire pulse

  ////////////////////////////////////////////////////////////////////
  // decode
  xid_form_t form;
  xid_addr_t addr;
  xid_byte_t lit;

  xid_decode u_decode
  (
    .i_op(i_op),
    .o_form(form),
    .o_addr(addr),
    .o_lit(lit)
  );

  ////////////////////////////////////////////////////////////////////
  // combinational result
  wire xid_byte_t fr_rd = fr_mem[addr]; // addressed_file_register
  wire is_lit = (form == XID_LIT);
  wire xid_byte_t operand = is_lit ? lit : fr_rd;
  wire xid_byte_t result = acc_q ^ operand;
  wire active = i_valid && (form != XID_NONE);
  wire res_zero = (result == `XID_ZERO);
  // only the register form writes the file; others leave it alone
  wire to_fr = active && (form == XID_TO_FR);

  // next values; the register form never touches the accumulator
  always_comb
  begin
    acc_d = acc_q;
    zero_d = zero_q; // no other flag lives here
    wr_d = '0;
    if (active)
    begin
      zero_d = res_zero;
      if (to_fr)
      begin
        wr_d.we = 1'b1;
        wr_d.addr = addr;
        wr_d.data = result;
      end
      // acc_d keeps its default here, so the register form leaves it alone
      else
      begin
        acc_d = result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers, all updated in the issue cycle with no stall
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      acc_q <= `XID_ACC_RST;
      zero_q <= 1'b0;
      wr_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      wr_q <= wr_d;
      done_q <= active;
    end
  end

  // file write; cleared on reset so that a read after reset is never unknown,
  // which costs a reset on every cell of this small array
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < `XID_FR_DEPTH; i++)
      begin
        fr_mem[i] <= `XID_FR_RST;
      end
    end
    else if (to_fr)
    begin
      fr_mem[addr] <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign o_acc = acc_q;
  assign o_zero = zero_q;
  assign o_fr_wr = wr_q;
  assign o_done = done_q;
endmodule

// >>> verification/xid_checker.sv
// port checker for the xor execute datapath
`timescale 1ns/100ps
module xid_checker
(
  // watched ports
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire xid_pkg::xid_op_t i_op,
  input wire xid_pkg::xid_fr_wr_t o_fr_wr,
  input wire xid_pkg::xid_byte_t o_acc,
  input wire logic o_zero,
  input wire logic o_done
);
  import xid_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // decoded forms, result is data when written back
  wire tf = i_valid && i_op[11:5] == 7'h0D;
  wire ta = i_valid && i_op[11:5] == 7'h0C;
  wire tl = i_valid && i_op[11:8] == 4'hF;
  wire [7:0] res = o_fr_wr.we ? o_fr_wr.data : o_acc;
  AST_FR_WR: assert property (tf |=> o_fr_wr.we && o_fr_wr.addr == $past(i_op[4:0]))
    else $error("register write wrong");
  AST_ACC_KEEP: assert property (tf |=> $stable(o_acc))
    else $error("acc changed");
  AST_ACC_DEST: assert property (ta |=> !o_fr_wr.we)
    else $error("register written");
  AST_LIT: assert property (tl |=> o_acc == ($past(o_acc) ^ $past(i_op[7:0])))
    else $error("literal result wrong");
  AST_Z_SET: assert property (o_done && res == 8'h00 |-> o_zero)
    else $error("zero not set");
  AST_Z_CLR: assert property (o_done && res != 8'h00 |-> !o_zero)
    else $error("zero not cleared");
  AST_ONE_CYC: assert property (tf || ta || tl |=> o_done)
    else $error("no done");
  cover property (tf);
  cover property (ta);
  cover property (o_done && o_zero);
endmodule

// >>> verification/tb.sv
// self-checking bench for the xor datapath
`timescale 1ns/100ps
module tb;
  import xid_pkg::*;
  logic i_clock = 0, i_sys_rst = 1, i_valid = 0;
  xid_op_t i_op = '0;
  xid_fr_wr_t o_fr_wr;
  xid_byte_t o_acc;
  logic o_zero, o_done;
  int err_total = 0, num_checks = 0;
  xid_datapath u_xid_datapath (.i_clock, .i_sys_rst, .i_valid, .i_op, .o_fr_wr, .o_acc,
    .o_zero, .o_done);
  initial forever #10 i_clock = ~i_clock;
  // one compare, counted
  task chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  // issue one word; outputs read while done still stands
  task ex(input xid_op_t op);
    @(posedge i_clock) i_valid <= 1'h1;
    i_op <= op;
    @(posedge i_clock) i_valid <= 1'h0;
    #1;
  endtask
  // 16-cycle synchronous reset
  task rst;
    i_sys_rst <= 1'h1;
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'h0;
  endtask
  // literal twice: nonzero, then back to zero
  task t_lit;
    ex(12'hF51);
    chk("lit1", {o_acc, o_zero, o_done}, {8'h51, 1'h0, 1'h1});
    ex(12'hF51);
    chk("lit2", {o_acc, o_zero, o_done}, {8'h00, 1'h1, 1'h1});
    $display("lit test done");
  endtask
  // register forms; the file is cleared by reset, so stored bytes are known
  task t_fr;
    ex(12'hF51);
    ex(12'h1B0);
    chk("tofr", {o_fr_wr.we, o_fr_wr.addr, o_fr_wr.data, o_acc, o_zero, o_done},
      {1'h1, 5'h10, 8'h51, 8'h51, 1'h0, 1'h1});
    ex(12'h190);
    chk("toacc", {o_fr_wr.we, o_acc, o_zero, o_done}, {1'h0, 8'h00, 1'h1, 1'h1});
    ex(12'h1B0);
    chk("frkept", {o_fr_wr.we, o_fr_wr.data, o_zero}, {1'h1, 8'h51, 1'h0});
    $display("fr test done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence, reset again mid-run to check a second release
  initial
  begin
    rst;
    t_lit;
    t_fr;
    rst;
    t_lit;
    results;
  end
  // watchdog well past the expected run
  initial
  begin
    #20000;
    err_total++;
    results;
  end
endmodule
bind xid_datapath xid_checker u_xid_checker (.i_clock, .i_sys_rst, .i_valid, .i_op, .o_fr_wr,
  .o_acc, .o_zero, .o_done);
